// ---- hdl/dirm_map.vh ----
// register offsets, reset values and codes of the digital input role mapper
`ifndef DIRM_MAP_VH
`define DIRM_MAP_VH

// *************************************************************
// register offsets (word index on the register port)
// *************************************************************
`define DIRM_ADDR_W            8
`define DIRM_OFS_IN1_ROLE      8'h03
`define DIRM_OFS_IN1_LOGIC     8'h04
`define DIRM_OFS_IN2_ROLE      8'h05
`define DIRM_OFS_IN2_LOGIC     8'h06
`define DIRM_OFS_IN3_ROLE      8'h07
`define DIRM_OFS_IN3_LOGIC     8'h08
`define DIRM_OFS_IN4_ROLE      8'h09
`define DIRM_OFS_STATUS        8'h20
`define DIRM_OFS_PENDING       8'h21

// *************************************************************
// reset values
// *************************************************************
`define DIRM_RST_IN1_ROLE      16'h000E
`define DIRM_RST_IN1_LOGIC     16'h0000
`define DIRM_RST_IN2_ROLE      16'h000F
`define DIRM_RST_IN2_LOGIC     16'h0000
`define DIRM_RST_IN3_ROLE      16'h0000
`define DIRM_RST_IN3_LOGIC     16'h0000
`define DIRM_RST_IN4_ROLE      16'h0000
`define DIRM_RST_IN4_LOGIC     3'h1

// *************************************************************
// ranges
// *************************************************************
`define DIRM_ROLE_MAX          16'h0027
`define DIRM_LOGIC_MAX         16'h0004

// *************************************************************
// logic types
// *************************************************************
`define DIRM_LT_LOW            3'h0
`define DIRM_LT_HIGH           3'h1
`define DIRM_LT_RISE           3'h2
`define DIRM_LT_FALL           3'h3
`define DIRM_LT_BOTH           3'h4

// *************************************************************
// role codes
// *************************************************************
`define DIRM_ROLE_NONE         6'h00
`define DIRM_ROLE_ALM_RST      6'h02
`define DIRM_ROLE_GAIN_SW      6'h03
`define DIRM_ROLE_ZCLAMP       6'h0C
`define DIRM_ROLE_POS_INH      6'h0D
`define DIRM_ROLE_PLIM         6'h0E
`define DIRM_ROLE_NLIM         6'h0F
`define DIRM_ROLE_FTLIM        6'h10
`define DIRM_ROLE_RTLIM        6'h11
`define DIRM_ROLE_FJOG         6'h12
`define DIRM_ROLE_RJOG         6'h13
`define DIRM_ROLE_TDIR         6'h19
`define DIRM_ROLE_SDIR         6'h1A
`define DIRM_ROLE_PDIR         6'h1B
`define DIRM_ROLE_HOME         6'h1F
`define DIRM_ROLE_ESTOP        6'h22
`define DIRM_ROLE_CLR_ERR      6'h23
`define DIRM_ROLE_SPD_LIM      6'h24
`define DIRM_ROLE_PROBE1       6'h26
`define DIRM_ROLE_PROBE2       6'h27

// *************************************************************
// function vector bit positions
// *************************************************************
`define DIRM_FN_W              18
`define DIRM_FN_ALM_RST        0
`define DIRM_FN_GAIN_SW        1
`define DIRM_FN_ZCLAMP         2
`define DIRM_FN_POS_INH        3
`define DIRM_FN_PLIM           4
`define DIRM_FN_NLIM           5
`define DIRM_FN_FTLIM          6
`define DIRM_FN_RTLIM          7
`define DIRM_FN_FJOG           8
`define DIRM_FN_RJOG           9
`define DIRM_FN_TDIR           10
`define DIRM_FN_SDIR           11
`define DIRM_FN_PDIR           12
`define DIRM_FN_HOME           13
`define DIRM_FN_ESTOP          14
`define DIRM_FN_CLR_ERR        15
`define DIRM_FN_SPD_LIM        16
`define DIRM_FN_PROBE          17

`endif

// ---- hdl/dirm_condition.v ----
// one input's logic-type conditioning: level or edge detect
`timescale 1ns/10ps
`include "dirm_map.vh"

module dirm_condition (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       pin_i,
    input  wire [2:0] logic_type_i,
    output reg        active_o
);

    reg prev;

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            prev     <= 1'b0;
            active_o <= 1'b0;
        end else begin
            prev <= pin_i;
            case (logic_type_i)
                `DIRM_LT_LOW:  active_o <= ~pin_i;
                `DIRM_LT_HIGH: active_o <= pin_i;
                `DIRM_LT_RISE: active_o <= pin_i & ~prev;
                `DIRM_LT_FALL: active_o <= ~pin_i & prev;
                `DIRM_LT_BOTH: active_o <= pin_i ^ prev;
                default:       active_o <= 1'b0;
            endcase
        end
    end

endmodule

// ---- hdl/dirm_decode.v ----
// role code to one-hot function decode
`timescale 1ns/10ps
`include "dirm_map.vh"

module dirm_decode (
    input  wire [5:0]             role_i,
    input  wire                   active_i,
    output reg  [`DIRM_FN_W-1:0] fn_o,
    output reg                    probe1_o,
    output reg                    probe2_o
);

    always @* begin
        fn_o     = {`DIRM_FN_W{1'b0}};
        probe1_o = 1'b0;
        probe2_o = 1'b0;
        case (role_i)
            `DIRM_ROLE_ALM_RST: fn_o[`DIRM_FN_ALM_RST] = active_i;
            `DIRM_ROLE_GAIN_SW: fn_o[`DIRM_FN_GAIN_SW] = active_i;
            `DIRM_ROLE_ZCLAMP:  fn_o[`DIRM_FN_ZCLAMP]  = active_i;
            `DIRM_ROLE_POS_INH: fn_o[`DIRM_FN_POS_INH] = active_i;
            `DIRM_ROLE_PLIM:    fn_o[`DIRM_FN_PLIM]    = active_i;
            `DIRM_ROLE_NLIM:    fn_o[`DIRM_FN_NLIM]    = active_i;
            `DIRM_ROLE_FTLIM:   fn_o[`DIRM_FN_FTLIM]   = active_i;
            `DIRM_ROLE_RTLIM:   fn_o[`DIRM_FN_RTLIM]   = active_i;
            `DIRM_ROLE_FJOG:    fn_o[`DIRM_FN_FJOG]    = active_i;
            `DIRM_ROLE_RJOG:    fn_o[`DIRM_FN_RJOG]    = active_i;
            `DIRM_ROLE_TDIR:    fn_o[`DIRM_FN_TDIR]    = active_i;
            `DIRM_ROLE_SDIR:    fn_o[`DIRM_FN_SDIR]    = active_i;
            `DIRM_ROLE_PDIR:    fn_o[`DIRM_FN_PDIR]    = active_i;
            `DIRM_ROLE_HOME:    fn_o[`DIRM_FN_HOME]    = active_i;
            `DIRM_ROLE_ESTOP:   fn_o[`DIRM_FN_ESTOP]   = active_i;
            `DIRM_ROLE_CLR_ERR: fn_o[`DIRM_FN_CLR_ERR] = active_i;
            `DIRM_ROLE_SPD_LIM: fn_o[`DIRM_FN_SPD_LIM] = active_i;
            `DIRM_ROLE_PROBE1:  probe1_o               = active_i;
            `DIRM_ROLE_PROBE2:  probe2_o               = active_i;
            default:            fn_o                   = {`DIRM_FN_W{1'b0}};
        endcase
    end

endmodule

// ---- hdl/dirm_top.v ----
// digital input role mapper: settings, staging, conditioning and routing
// What this block does
// - code 0 none, 2 alarm reset, 3 gain switch
// - code 12 zero clamp, 13 position inhibit
// - code 14/15 positive/negative travel limit
// - code 16/17 forward/reverse torque limit
// - code 18/19 forward/reverse jog
// - codes 25-27 torque/speed/position direction select
// - code 31 home switch, 34 emergency stop
// - code 35 clear error, 36 speed limit source
// - codes 38/39 touch probe one/two trigger
// - role selectors 16-bit, range 0-39, shared table
// - logic 0 active low, 1 active high
// - logic 2/3/4 rise/fall/either edge; range 0-4
// - new settings take effect only at stop
`timescale 1ns/10ps
`include "dirm_map.vh"

module dirm_top (
    input  wire                    clk_i,
    input  wire                    rstn_i,
    input  wire [`DIRM_ADDR_W-1:0] addr_i,
    input  wire [15:0]             wdata_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    output reg  [15:0]             rdata_o,
    input  wire                    drive_stopped_i,
    input  wire                    discrete_input_one_i,
    input  wire                    discrete_input_two_i,
    input  wire                    discrete_input_three_i,
    input  wire                    discrete_input_four_i,
    output wire                    alarm_reset_o,
    output wire                    gain_switch_o,
    output wire                    zero_clamp_o,
    output wire                    pos_cmd_inhibit_o,
    output wire                    pos_limit_o,
    output wire                    neg_limit_o,
    output wire                    fwd_torque_limit_o,
    output wire                    rev_torque_limit_o,
    output wire                    fwd_jog_o,
    output wire                    rev_jog_o,
    output wire                    torque_dir_sel_o,
    output wire                    speed_dir_sel_o,
    output wire                    pos_dir_sel_o,
    output wire                    home_switch_o,
    output wire                    emergency_stop_o,
    output wire                    clear_pos_error_o,
    output wire                    speed_limit_src_o,
    output wire                    probe1_trigger_o,
    output wire                    probe2_trigger_o
);

    // *************************************************************
    // staged settings (what software wrote)
    // *************************************************************
    reg [15:0] input_one_role_select;
    reg [15:0] input_one_logic_type;
    reg [15:0] input_two_role_select;
    reg [15:0] input_two_logic_type;
    reg [15:0] input_three_role_select;
    reg [15:0] input_three_logic_type;
    reg [15:0] input_four_role_select;

    // *************************************************************
    // active settings (what the logic uses)
    // *************************************************************
    reg [5:0] act_role [0:3];
    reg [2:0] act_logic [0:3];

    // reset values cut to the width of the active copies
    localparam [15:0] RST_ROLE_1  = `DIRM_RST_IN1_ROLE;
    localparam [15:0] RST_ROLE_2  = `DIRM_RST_IN2_ROLE;
    localparam [15:0] RST_ROLE_3  = `DIRM_RST_IN3_ROLE;
    localparam [15:0] RST_ROLE_4  = `DIRM_RST_IN4_ROLE;
    localparam [15:0] RST_LOGIC_1 = `DIRM_RST_IN1_LOGIC;
    localparam [15:0] RST_LOGIC_2 = `DIRM_RST_IN2_LOGIC;
    localparam [15:0] RST_LOGIC_3 = `DIRM_RST_IN3_LOGIC;

    wire role_ok  = (wdata_i <= `DIRM_ROLE_MAX);
    wire logic_ok = (wdata_i <= `DIRM_LOGIC_MAX);

    // *************************************************************
    // register writes
    // *************************************************************
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            input_one_role_select   <= `DIRM_RST_IN1_ROLE;
            input_one_logic_type    <= `DIRM_RST_IN1_LOGIC;
            input_two_role_select   <= `DIRM_RST_IN2_ROLE;
            input_two_logic_type    <= `DIRM_RST_IN2_LOGIC;
            input_three_role_select <= `DIRM_RST_IN3_ROLE;
            input_three_logic_type  <= `DIRM_RST_IN3_LOGIC;
            input_four_role_select  <= `DIRM_RST_IN4_ROLE;
        end else if (wr_i) begin
            // out-of-range writes are ignored, old value kept
            case (addr_i)
                `DIRM_OFS_IN1_ROLE:   if (role_ok)  input_one_role_select   <= wdata_i;
                `DIRM_OFS_IN1_LOGIC:  if (logic_ok) input_one_logic_type    <= wdata_i;
                `DIRM_OFS_IN2_ROLE:   if (role_ok)  input_two_role_select   <= wdata_i;
                `DIRM_OFS_IN2_LOGIC:  if (logic_ok) input_two_logic_type    <= wdata_i;
                `DIRM_OFS_IN3_ROLE:   if (role_ok)  input_three_role_select <= wdata_i;
                `DIRM_OFS_IN3_LOGIC:  if (logic_ok) input_three_logic_type  <= wdata_i;
                `DIRM_OFS_IN4_ROLE:   if (role_ok)  input_four_role_select  <= wdata_i;
                default: ;
            endcase
        end
    end

    // *************************************************************
    // apply staged settings only while the drive is stopped
    // *************************************************************
    wire pending = (act_role[0] != input_one_role_select[5:0])
                 | (act_role[1] != input_two_role_select[5:0])
                 | (act_role[2] != input_three_role_select[5:0])
                 | (act_role[3] != input_four_role_select[5:0])
                 | (act_logic[0] != input_one_logic_type[2:0])
                 | (act_logic[1] != input_two_logic_type[2:0])
                 | (act_logic[2] != input_three_logic_type[2:0]);

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            act_role[0]  <= RST_ROLE_1[5:0];
            act_role[1]  <= RST_ROLE_2[5:0];
            act_role[2]  <= RST_ROLE_3[5:0];
            act_role[3]  <= RST_ROLE_4[5:0];
            act_logic[0] <= RST_LOGIC_1[2:0];
            act_logic[1] <= RST_LOGIC_2[2:0];
            act_logic[2] <= RST_LOGIC_3[2:0];
            act_logic[3] <= `DIRM_RST_IN4_LOGIC;
        end else if (drive_stopped_i) begin
            act_role[0]  <= input_one_role_select[5:0];
            act_role[1]  <= input_two_role_select[5:0];
            act_role[2]  <= input_three_role_select[5:0];
            act_role[3]  <= input_four_role_select[5:0];
            act_logic[0] <= input_one_logic_type[2:0];
            act_logic[1] <= input_two_logic_type[2:0];
            act_logic[2] <= input_three_logic_type[2:0];
        end
    end

    // *************************************************************
    // register reads
    // *************************************************************
    wire [3:0] conditioned;

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `DIRM_OFS_IN1_ROLE:  rdata_o <= input_one_role_select;
                `DIRM_OFS_IN1_LOGIC: rdata_o <= input_one_logic_type;
                `DIRM_OFS_IN2_ROLE:  rdata_o <= input_two_role_select;
                `DIRM_OFS_IN2_LOGIC: rdata_o <= input_two_logic_type;
                `DIRM_OFS_IN3_ROLE:  rdata_o <= input_three_role_select;
                `DIRM_OFS_IN3_LOGIC: rdata_o <= input_three_logic_type;
                `DIRM_OFS_IN4_ROLE:  rdata_o <= input_four_role_select;
                `DIRM_OFS_STATUS:    rdata_o <= {12'h000, conditioned};
                `DIRM_OFS_PENDING:   rdata_o <= {15'h0000, pending};
                default:             rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // *************************************************************
    // per-input conditioning and decode
    // *************************************************************
    wire [3:0]            pins = {discrete_input_four_i, discrete_input_three_i,
                                  discrete_input_two_i, discrete_input_one_i};
    wire [`DIRM_FN_W-1:0] fn    [0:3];
    wire [3:0]            pr1;
    wire [3:0]            pr2;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_in
            dirm_condition u_cond (
                .clk_i        (clk_i),
                .rstn_i       (rstn_i),
                .pin_i        (pins[gi]),
                .logic_type_i (act_logic[gi]),
                .active_o     (conditioned[gi])
            );
            dirm_decode u_dec (
                .role_i   (act_role[gi]),
                .active_i (conditioned[gi]),
                .fn_o     (fn[gi]),
                .probe1_o (pr1[gi]),
                .probe2_o (pr2[gi])
            );
        end
    endgenerate

    // several inputs on one role are or-ed together
    wire [`DIRM_FN_W-1:0] fn_all = fn[0] | fn[1] | fn[2] | fn[3];

    assign alarm_reset_o      = fn_all[`DIRM_FN_ALM_RST];
    assign gain_switch_o      = fn_all[`DIRM_FN_GAIN_SW];
    assign zero_clamp_o       = fn_all[`DIRM_FN_ZCLAMP];
    assign pos_cmd_inhibit_o  = fn_all[`DIRM_FN_POS_INH];
    assign pos_limit_o        = fn_all[`DIRM_FN_PLIM];
    assign neg_limit_o        = fn_all[`DIRM_FN_NLIM];
    assign fwd_torque_limit_o = fn_all[`DIRM_FN_FTLIM];
    assign rev_torque_limit_o = fn_all[`DIRM_FN_RTLIM];
    assign fwd_jog_o          = fn_all[`DIRM_FN_FJOG];
    assign rev_jog_o          = fn_all[`DIRM_FN_RJOG];
    assign torque_dir_sel_o   = fn_all[`DIRM_FN_TDIR];
    assign speed_dir_sel_o    = fn_all[`DIRM_FN_SDIR];
    assign pos_dir_sel_o      = fn_all[`DIRM_FN_PDIR];
    assign home_switch_o      = fn_all[`DIRM_FN_HOME];
    assign emergency_stop_o   = fn_all[`DIRM_FN_ESTOP];
    assign clear_pos_error_o  = fn_all[`DIRM_FN_CLR_ERR];
    assign speed_limit_src_o  = fn_all[`DIRM_FN_SPD_LIM];
    assign probe1_trigger_o   = |pr1;
    assign probe2_trigger_o   = |pr2;

endmodule

// ---- bench/dirm_switches.sv ----
// model of the switches and sensors on the four discrete input terminals
`timescale 1ns/10ps

module dirm_switches #(
    parameter SLOW = 0
) (
    input  wire logic       clk_i,
    input  wire logic [3:0] level_i,
    output wire logic [3:0] pin_o
);
    logic [3:0] late;

    // slow contacts show the commanded level one cycle late
    always @(posedge clk_i) begin
        late <= level_i;
    end

    assign pin_o = (SLOW != 0) ? late : level_i;
endmodule

// ---- bench/dirm_top_props.sv ----
// assertions on the register port and outputs of the role mapper
`timescale 1ns/10ps

module dirm_top_props (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        drive_stopped_i,
    input wire logic        discrete_input_one_i,
    input wire logic        discrete_input_two_i,
    input wire logic        discrete_input_three_i,
    input wire logic        discrete_input_four_i,
    input wire logic        pos_limit_o,
    input wire logic        fwd_jog_o,
    input wire logic        zero_clamp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    wire [3:0] ins = {discrete_input_four_i, discrete_input_three_i, discrete_input_two_i, discrete_input_one_i};
    wire [2:0] fns = {pos_limit_o, fwd_jog_o, zero_clamp_o};

    property p_rdata_idle;
        !rd_i |=> rdata_o == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

    property p_unmapped;
        rd_i && addr_i == 8'h00 |=> rdata_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_role_back;
        wr_i && addr_i == 8'h03 && wdata_i <= 16'h0027 ##1 rd_i && addr_i == 8'h03 |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_role_back: assert property (p_role_back) else $error("role readback wrong");

    property p_role_refuse;
        wr_i && addr_i == 8'h03 && wdata_i > 16'h0027 ##1 rd_i && addr_i == 8'h03 |=> rdata_o <= 16'h0027;
    endproperty
    a_role_refuse: assert property (p_role_refuse) else $error("role out of range kept");

    property p_logic_back;
        wr_i && addr_i == 8'h04 && wdata_i <= 16'h0004 ##1 rd_i && addr_i == 8'h04 |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_logic_back: assert property (p_logic_back) else $error("logic readback wrong");

    property p_logic_refuse;
        wr_i && addr_i == 8'h04 && wdata_i > 16'h0004 ##1 rd_i && addr_i == 8'h04 |=> rdata_o <= 16'h0004;
    endproperty
    a_logic_refuse: assert property (p_logic_refuse) else $error("logic out of range kept");

    property p_pending_clear;
        (drive_stopped_i && !wr_i) [*2] ##0 rd_i && addr_i == 8'h21 |=> rdata_o == 16'h0000;
    endproperty
    a_pending_clear: assert property (p_pending_clear) else $error("pending set while stopped");

    property p_hold_running;
        (!drive_stopped_i && $stable(ins)) [*3] |=> $stable(fns);
    endproperty
    a_hold_running: assert property (p_hold_running) else $error("outputs moved while running");

    c_write_role: cover property (wr_i && addr_i == 8'h03);
    c_run_stop: cover property (!drive_stopped_i ##1 drive_stopped_i);
    c_jog_pulse: cover property ($rose(fwd_jog_o) ##1 $fell(fwd_jog_o));
endmodule

bind dirm_top dirm_top_props u_props (
    .clk_i                  (clk_i),
    .rstn_i                 (rstn_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rdata_o                (rdata_o),
    .drive_stopped_i        (drive_stopped_i),
    .discrete_input_one_i   (discrete_input_one_i),
    .discrete_input_two_i   (discrete_input_two_i),
    .discrete_input_three_i (discrete_input_three_i),
    .discrete_input_four_i  (discrete_input_four_i),
    .pos_limit_o            (pos_limit_o),
    .fwd_jog_o              (fwd_jog_o),
    .zero_clamp_o           (zero_clamp_o)
);

// ---- bench/digital_input_role_mapper_tb_top.sv ----
// self-checking bench of the digital input role mapper
`timescale 1ns/10ps

module digital_input_role_mapper_tb_top;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        drive_stopped_i = 1'b1;
    logic [3:0]  level = 4'h0;
    wire  [3:0]  pins;
    wire  [15:0] rdata_o;
    wire  [18:0] fn;
    int          miscompares = 0;
    int          num_checks = 0;
    int          row_role[23] = '{0, 1, 2, 3, 12, 13, 14, 15, 16, 17, 18, 19, 25, 26, 27, 31, 34, 35, 36, 38, 39, 20, 37};
    int          row_pos[23] = '{31, 31, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 31, 31};
    logic [15:0] rst_val[7] = '{16'h000E, 16'h0000, 16'h000F, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    always #12.5 clk_i = ~clk_i;

    dirm_switches sw (.clk_i(clk_i), .level_i(level), .pin_o(pins));

    dirm_top dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .drive_stopped_i(drive_stopped_i),
        .discrete_input_one_i(pins[0]), .discrete_input_two_i(pins[1]),
        .discrete_input_three_i(pins[2]), .discrete_input_four_i(pins[3]),
        .alarm_reset_o(fn[0]), .gain_switch_o(fn[1]), .zero_clamp_o(fn[2]), .pos_cmd_inhibit_o(fn[3]),
        .pos_limit_o(fn[4]), .neg_limit_o(fn[5]), .fwd_torque_limit_o(fn[6]), .rev_torque_limit_o(fn[7]),
        .fwd_jog_o(fn[8]), .rev_jog_o(fn[9]), .torque_dir_sel_o(fn[10]), .speed_dir_sel_o(fn[11]),
        .pos_dir_sel_o(fn[12]), .home_switch_o(fn[13]), .emergency_stop_o(fn[14]),
        .clear_pos_error_o(fn[15]), .speed_limit_src_o(fn[16]), .probe1_trigger_o(fn[17]),
        .probe2_trigger_o(fn[18])
    );

    task tick;
        @(posedge clk_i);
        #1;
    endtask

    task check(input string what, input logic [18:0] seen, input logic [18:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        rd_i <= 1'b0;
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        tick;
    endtask

    // strobes low at once, without waiting for a clock edge
    task bus_idle;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask

    // read strobe for one cycle, data checked in the following cycle
    task chk_reg(input logic [7:0] a, input logic [15:0] exp);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        tick;
        check("rdata", {3'b000, rdata_o}, {3'b000, exp});
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        miscompares++;
        stop_test;
    end

    initial begin
        repeat (16) tick;
        rstn_i <= 1'b1;
        tick;
        for (int i = 0; i < 7; i++) chk_reg(8'h03 + i[7:0], rst_val[i]);
        chk_reg(8'h00, 16'h0000);
        check("fn", fn, 19'h00030);
        $display("reset test done");
        wr_reg(8'h04, 16'h0001);
        wr_reg(8'h06, 16'h0001);
        for (int i = 0; i < 23; i++) begin
            wr_reg(8'h03, row_role[i][15:0]);
            bus_idle;
            level[0] <= 1'b1;
            tick;
            check("fn", fn, (row_pos[i] < 19) ? (19'h00001 << row_pos[i]) : 19'h00000);
            level[0] <= 1'b0;
            tick;
            check("fn", fn, 19'h00000);
        end
        $display("role table test done");
        wr_reg(8'h03, 16'h0028);
        chk_reg(8'h03, 16'h0025);
        wr_reg(8'h04, 16'h0005);
        chk_reg(8'h04, 16'h0001);
        wr_reg(8'h03, 16'h0012);
        chk_reg(8'h03, 16'h0012);
        for (int lt = 0; lt < 5; lt++) begin
            wr_reg(8'h04, lt[15:0]);
            chk_reg(8'h04, lt[15:0]);
            bus_idle;
            repeat (3) tick;
            check("jog", fn[8], lt == 0);
            level[0] <= 1'b1;
            tick;
            check("jog", fn[8], lt == 1 || lt == 2 || lt == 4);
            tick;
            check("jog", fn[8], lt == 1);
            level[0] <= 1'b0;
            tick;
            check("jog", fn[8], lt == 0 || lt == 3 || lt == 4);
            tick;
            check("jog", fn[8], lt == 0);
        end
        $display("logic type test done");
        wr_reg(8'h03, 16'h000C);
        wr_reg(8'h04, 16'h0001);
        bus_idle;
        tick;
        level[0] <= 1'b1;
        drive_stopped_i <= 1'b0;
        wr_reg(8'h03, 16'h0012);
        bus_idle;
        repeat (3) tick;
        check("fn", fn, 19'h00004);
        chk_reg(8'h21, 16'h0001);
        drive_stopped_i <= 1'b1;
        bus_idle;
        repeat (2) tick;
        check("fn", fn, 19'h00100);
        chk_reg(8'h21, 16'h0000);
        $display("run and stop test done");
        wr_reg(8'h03, 16'h0000);
        wr_reg(8'h05, 16'h001F);
        wr_reg(8'h07, 16'h0022);
        wr_reg(8'h08, 16'h0003);
        wr_reg(8'h09, 16'h0026);
        bus_idle;
        level <= 4'b0110;
        repeat (2) tick;
        check("fn", fn, 19'h02000);
        level <= 4'b1010;
        tick;
        check("fn", fn, 19'h26000);
        tick;
        check("fn", fn, 19'h22000);
        chk_reg(8'h20, 16'h000A);
        $display("multi input test done");
        stop_test;
    end
endmodule
